// ===== core/ccsr_pkg.sv
// ccsr_pkg: constants and types for the card configuration and status registers
package ccsr_pkg;

  // ==========================================================================
  // widths
  localparam int CFG_W      = 64;
  localparam int STAT_W     = 32;
  localparam int CFG_RSVD_W = 16;
  localparam int CFG_MFR_W  = 32;

  // ==========================================================================
  // configuration register fields
  localparam int                 CFG_LAYOUT_LSB   = 60;
  localparam int                 CFG_PHYS_LSB     = 56;
  localparam int                 CFG_ERASE_BIT    = 55;
  localparam int                 CFG_SEC_LSB      = 52;
  localparam int                 CFG_WIDTH_LSB    = 48;
  localparam logic [3:0]         LAYOUT_V1_0      = 4'h0;
  localparam logic [3:0]         PHYS_V1_01       = 4'h0;
  localparam logic               ERASE_DEFAULT    = 1'b0;
  localparam logic [2:0]         SEC_NONE         = 3'h0;
  localparam logic [2:0]         SEC_PROT_2_0     = 3'h2;
  localparam logic [3:0]         WIDTH_DEFAULT    = 4'h5;
  localparam logic [3:0]         WIDTH_REQ_MASK   = 4'h5;
  localparam logic [3:0]         WIDTH_RSVD_MASK  = 4'ha;
  localparam logic [15:0]        CFG_RSVD_VAL     = 16'h0000;
  localparam logic [31:0]        CFG_MFR_VAL      = 32'h0000_0000;
  localparam logic [CFG_W-1:0]   CFG_DATA_RESET   = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // status word bit positions
  localparam int BIT_ARG_RANGE_FAULT     = 31;
  localparam int BIT_ADDR_ALIGN_FAULT    = 30;
  localparam int BIT_XFER_LENGTH_FAULT   = 29;
  localparam int BIT_ERASE_ORDER_FAULT   = 28;
  localparam int BIT_ERASE_SELECT_FAULT  = 27;
  localparam int BIT_PROTECTED_WR_FAULT  = 26;
  localparam int BIT_HOST_LOCK_FLAG      = 25;
  localparam int BIT_LOCK_CMD_FAULT      = 24;
  localparam int BIT_CMD_CHECK_FAULT     = 23;
  localparam int BIT_STATE_CMD_FAULT     = 22;
  localparam int BIT_ECC_UNCORR_FAULT    = 21;
  localparam int BIT_CONTROLLER_FAULT    = 20;
  localparam int BIT_GENERAL_FAULT       = 19;
  localparam int BIT_RSVD_HI             = 18;
  localparam int BIT_RSVD_LO             = 17;
  localparam int BIT_ID_REG_REWRITE_FAULT = 16;
  localparam int BIT_ERASE_SKIP_FLAG     = 15;
  localparam int BIT_ECC_OFF_FLAG        = 14;
  localparam int BIT_ERASE_ABORT_FLAG    = 13;
  localparam int STATE_LSB               = 9;
  localparam logic [STAT_W-1:0] STAT_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    CS_IDLE, CS_READY, CS_IDENT, CS_STANDBY, CS_TRANSFER,
    CS_DATA, CS_RECEIVE, CS_PROGRAM, CS_DISCONNECT
  } ccsr_card_state_t;

  // one-hot status mask for a bit position
  function automatic logic [STAT_W-1:0] stat_bit(input int pos);
    logic [STAT_W-1:0] m;
    m = STAT_RESET;
    m[pos] = 1'b1;
    return m;
  endfunction

endpackage

// ===== core/ccsr_flag_if.sv
// ccsr_flag_if: set, clear and flag vectors between the status logic and its flag bank
`timescale 1ns/1ps
interface ccsr_flag_if;
  logic [ccsr_pkg::STAT_W-1:0] set_vec;
  logic [ccsr_pkg::STAT_W-1:0] clr_vec;
  logic [ccsr_pkg::STAT_W-1:0] flags;

  modport owner (
    input  set_vec,
    input  clr_vec,
    output flags
  );

  modport user (
    output set_vec,
    output clr_vec,
    input  flags
  );
endinterface

// ===== core/ccsr_flag_bank.sv
// ccsr_flag_bank: sticky status flags where a set always beats a clear
`timescale 1ns/1ps
module ccsr_flag_bank #(
  parameter logic [ccsr_pkg::STAT_W-1:0] KEEP_MASK = 32'hffff_ffff
) (
  input wire logic   core_clk,
  input wire logic   resetn,
  ccsr_flag_if.owner flg
);
  import ccsr_pkg::*;

  // ==========================================================================
  // flag storage
  // bits outside KEEP_MASK never hold state, so reserved bits stay at zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flg.flags <= STAT_RESET;
    end else begin
      flg.flags <= ((flg.flags & ~flg.clr_vec) | flg.set_vec) & KEEP_MASK;
    end
  end

endmodule

// ===== core/ccsr_regs.sv
// ccsr_regs: fixed card feature configuration and the upper card status word
// Operation
// - 64-bit read-only factory feature configuration word
// - bits 63:60 report layout version, 0
// - bits 59:56 report physical-layer revision, 0
// - bit 55 reports erased data value zero
// - bits 54:52 security algorithm code, two
// - writable card must report non-zero security
// - bits 51:48 width mask, at least 0101
// - bits 47:0 read as zero
// - execution flags set anytime, returned on poll
// - response flags set for causing command
// - previous-command flags delayed clear; others clear-on-read
// - bit 31 argument arg_range_fault
// - bit 30 misaligned address, clear on read
// - bit 29 bad block length, clear on read
// - bits 28, 27 erase order and selection
// - bit 26 protected write; bit 15 skip
// - bit 25 follows host lock state
// - bits 23, 22 check and state faults
// - bits 21, 20, 19 faults; 14 ecc off
// - bit 16 identity or protect rewrite fault
// - bit 13 erase sequence abandoned, clear-on-read
// - bits 12:9 card state at reception
`timescale 1ns/1ps
module ccsr_regs #(
  parameter logic [2:0] SECURITY_CODE = ccsr_pkg::SEC_PROT_2_0,
  parameter logic [3:0] WIDTH_MASK    = ccsr_pkg::WIDTH_DEFAULT,
  parameter logic       ERASE_VALUE   = ccsr_pkg::ERASE_DEFAULT,
  parameter logic       WRITABLE      = 1'b1
) (
  input  wire logic                              core_clk,
  input  wire logic                              resetn,
  input  wire logic                              cmd_rx,
  input  wire logic                              cmd_crc_fail,
  input  wire logic                              cmd_illegal,
  input  wire logic [ccsr_pkg::STAT_W-1:0]       resp_set,
  input  wire logic [ccsr_pkg::STAT_W-1:0]       exec_set,
  input  wire logic                              host_lock_flag,
  input  wire logic                              ecc_off,
  input  wire ccsr_pkg::ccsr_card_state_t        card_state,
  input  wire logic                              cfg_rd,
  output      logic                              cfg_ack,
  output      logic [ccsr_pkg::CFG_W-1:0]        cfg_data,
  output      logic                              resp_valid,
  output      logic [ccsr_pkg::STAT_W-1:0]       resp_status
);
  import ccsr_pkg::*;

  // ==========================================================================
  // elaboration checks
  generate
    if (WRITABLE && (SECURITY_CODE == SEC_NONE)) begin : g_chk_sec
      $error("writable card needs a security code");
    end
    if (SECURITY_CODE > SEC_PROT_2_0) begin : g_chk_sec_rsvd
      $error("security code is reserved");
    end
    if ((WIDTH_MASK & WIDTH_REQ_MASK) != WIDTH_REQ_MASK) begin : g_chk_width
      $error("one-line and four-line widths must both be set");
    end
    if ((WIDTH_MASK & WIDTH_RSVD_MASK) != 4'h0) begin : g_chk_width_rsvd
      $error("reserved bus width bits set");
    end
  endgenerate

  // ==========================================================================
  // feature configuration word
  localparam logic [CFG_W-1:0] CFG_WORD = {
    LAYOUT_V1_0,
    PHYS_V1_01,
    ERASE_VALUE,
    SECURITY_CODE,
    WIDTH_MASK,
    CFG_RSVD_VAL,
    CFG_MFR_VAL
  };

  // held in flip-flops only so the read data comes from a register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_data <= CFG_DATA_RESET;
    end else if (cfg_rd) begin
      cfg_data <= CFG_WORD;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd;
    end
  end

  // ==========================================================================
  // status bit classes
  // execution-time faults, settable at any time
  localparam logic [STAT_W-1:0] EXEC_MASK =
    stat_bit(BIT_ARG_RANGE_FAULT)      |
    stat_bit(BIT_ERASE_SELECT_FAULT)   |
    stat_bit(BIT_PROTECTED_WR_FAULT)   |
    stat_bit(BIT_ERASE_SKIP_FLAG)      |
    stat_bit(BIT_LOCK_CMD_FAULT)       |
    stat_bit(BIT_ECC_UNCORR_FAULT)     |
    stat_bit(BIT_CONTROLLER_FAULT)     |
    stat_bit(BIT_GENERAL_FAULT)        |
    stat_bit(BIT_ID_REG_REWRITE_FAULT);

  // faults found while decoding the command being answered
  localparam logic [STAT_W-1:0] RESP_MASK =
    stat_bit(BIT_ADDR_ALIGN_FAULT)     |
    stat_bit(BIT_XFER_LENGTH_FAULT)    |
    stat_bit(BIT_ERASE_ORDER_FAULT)    |
    stat_bit(BIT_ERASE_ABORT_FLAG);

  // faults of a command that got no answer, shown on the next one
  localparam logic [STAT_W-1:0] PREV_MASK =
    stat_bit(BIT_CMD_CHECK_FAULT)      |
    stat_bit(BIT_STATE_CMD_FAULT);

  localparam logic [STAT_W-1:0] READ_CLR_MASK = EXEC_MASK | RESP_MASK;
  localparam logic [STAT_W-1:0] KEEP_MASK     = READ_CLR_MASK | PREV_MASK;

  // ==========================================================================
  // flag bank
  ccsr_flag_if flg ();

  logic [STAT_W-1:0] next_set;
  logic [STAT_W-1:0] next_clr;
  logic [STAT_W-1:0] resp_hits;
  logic [STAT_W-1:0] exec_hits;

  always_comb begin
    exec_hits = exec_set & EXEC_MASK;
    resp_hits = cmd_rx ? (resp_set & RESP_MASK) : STAT_RESET;
  end

  always_comb begin
    // response faults go out at once; storing them would report them twice
    next_set = exec_hits;
    if (cmd_crc_fail) begin
      next_set = next_set | stat_bit(BIT_CMD_CHECK_FAULT);
    end
    if (cmd_illegal) begin
      next_set = next_set | stat_bit(BIT_STATE_CMD_FAULT);
    end
  end

  // every answered command reports the flags, so that is the read that clears
  always_comb begin
    if (cmd_rx) begin
      next_clr = READ_CLR_MASK | PREV_MASK;
    end else begin
      next_clr = STAT_RESET;
    end
  end

  assign flg.set_vec = next_set;
  assign flg.clr_vec = next_clr;

  ccsr_flag_bank #(
    .KEEP_MASK (KEEP_MASK)
  ) u_flags (
    .core_clk (core_clk),
    .resetn   (resetn),
    .flg      (flg)
  );

  // ==========================================================================
  // response word
  // faults of a rejected command in this cycle are left for the next answer
  logic [STAT_W-1:0] next_status;

  always_comb begin
    next_status = flg.flags | exec_hits | resp_hits;
    next_status[BIT_HOST_LOCK_FLAG] = host_lock_flag;
    next_status[BIT_ECC_OFF_FLAG] = ecc_off;
    next_status[STATE_LSB +: 4] = card_state;
    next_status[BIT_RSVD_HI] = 1'b0;
    next_status[BIT_RSVD_LO] = 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      resp_status <= STAT_RESET;
    end else if (cmd_rx) begin
      resp_status <= next_status;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= cmd_rx;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_cfg_read_word:
  assert property (cfg_rd |=> cfg_ack && (cfg_data == CFG_WORD))
    else $error("configuration read returned the wrong word");

  a_cfg_version_codes:
  assert property (cfg_ack |-> (cfg_data[CFG_LAYOUT_LSB +: 4] == LAYOUT_V1_0) &&
                               (cfg_data[CFG_PHYS_LSB +: 4] == PHYS_V1_01))
    else $error("layout or physical version code wrong");

  a_cfg_security_code:
  assert property (cfg_ack |-> (cfg_data[CFG_SEC_LSB +: 3] == SECURITY_CODE) &&
                               (!WRITABLE || (cfg_data[CFG_SEC_LSB +: 3] != SEC_NONE)))
    else $error("security code wrong");

  a_cfg_width_erase:
  assert property (cfg_ack |-> cfg_data[CFG_WIDTH_LSB] && cfg_data[CFG_WIDTH_LSB + 2] &&
                               (cfg_data[CFG_ERASE_BIT] == ERASE_VALUE))
    else $error("width mask or erase value wrong");

  a_cfg_reserved_zero:
  assert property (cfg_ack |-> (cfg_data[CFG_RSVD_W + CFG_MFR_W - 1:0] == '0))
    else $error("reserved configuration bits not zero");

  a_resp_pulse_once:
  assert property (cmd_rx |=> resp_valid ##1 (resp_valid == $past(cmd_rx)))
    else $error("answer strobe not one per command");

  a_resp_fault_shown:
  assert property (cmd_rx && resp_set[BIT_ADDR_ALIGN_FAULT]
                   |=> resp_valid && resp_status[BIT_ADDR_ALIGN_FAULT])
    else $error("response fault missing from its own answer");

  sequence s_exec_then_poll;
    exec_set[BIT_ARG_RANGE_FAULT] && !cmd_rx ##1 cmd_rx;
  endsequence

  a_exec_poll_seen:
  assert property (s_exec_then_poll |=> resp_status[BIT_ARG_RANGE_FAULT])
    else $error("execution fault not returned on the next poll");

  sequence s_quiet_report;
    cmd_rx && !exec_set[BIT_ARG_RANGE_FAULT];
  endsequence

  a_read_clears:
  assert property (s_quiet_report ##1 s_quiet_report |=> !resp_status[BIT_ARG_RANGE_FAULT])
    else $error("clear-on-read flag reported twice");

  sequence s_bad_then_two;
    cmd_crc_fail && !cmd_rx ##1 (cmd_rx && !cmd_crc_fail) ##1 (cmd_rx && !cmd_crc_fail);
  endsequence

  a_prev_cmd_delay:
  assert property (s_bad_then_two |-> resp_status[BIT_CMD_CHECK_FAULT]
                                      ##1 !resp_status[BIT_CMD_CHECK_FAULT])
    else $error("check fault not shown once on the following answer");

  a_illegal_next:
  assert property (cmd_illegal && !cmd_rx ##1 cmd_rx |=> resp_status[BIT_STATE_CMD_FAULT])
    else $error("state fault missing from the next answer");

  a_no_answer_on_bad:
  assert property (cmd_illegal && !cmd_rx |=> !resp_valid && $stable(resp_status))
    else $error("rejected command changed the answer");

  a_levels_follow:
  assert property (cmd_rx |=> (resp_status[BIT_HOST_LOCK_FLAG] == $past(host_lock_flag)) &&
                              (resp_status[BIT_ECC_OFF_FLAG] == $past(ecc_off)))
    else $error("lock or ecc level not captured");

  a_state_code:
  assert property (cmd_rx |=> resp_status[STATE_LSB +: 4] == $past(card_state))
    else $error("card state at reception not reported");

  a_erase_abort:
  assert property (cmd_rx && resp_set[BIT_ERASE_ABORT_FLAG]
                   |=> resp_status[BIT_ERASE_ABORT_FLAG])
    else $error("erase abandon not reported");

  a_reserved_zero:
  assert property (resp_valid |-> !resp_status[BIT_RSVD_HI] && !resp_status[BIT_RSVD_LO] &&
                                  (resp_status[STATE_LSB-1:0] == '0))
    else $error("reserved status bits set");

  a_len_shown:
  assert property (cmd_rx && resp_set[BIT_XFER_LENGTH_FAULT]
                   |=> resp_valid && resp_status[BIT_XFER_LENGTH_FAULT])
    else $error("block length fault missing from its answer");

  a_erase_order_shown:
  assert property (cmd_rx && resp_set[BIT_ERASE_ORDER_FAULT]
                   |=> resp_valid && resp_status[BIT_ERASE_ORDER_FAULT])
    else $error("erase order fault missing from its answer");

  sequence s_len_then_clean;
    (cmd_rx && resp_set[BIT_XFER_LENGTH_FAULT]) ##2 (cmd_rx && !resp_set[BIT_XFER_LENGTH_FAULT]);
  endsequence

  a_resp_not_sticky:
  assert property (s_len_then_clean |=> !resp_status[BIT_XFER_LENGTH_FAULT])
    else $error("response fault reported twice");

  a_cfg_ack_idle:
  assert property (!cfg_rd |=> !cfg_ack)
    else $error("configuration ack without a read");

  a_cfg_data_holds:
  assert property (!cfg_rd |=> $stable(cfg_data))
    else $error("configuration word changed without a read");

  a_select_flag_set:
  assert property (exec_set[BIT_ERASE_SELECT_FAULT] |=> flg.flags[BIT_ERASE_SELECT_FAULT])
    else $error("erase selection fault not stored");

  a_protect_flags_set:
  assert property (exec_set[BIT_PROTECTED_WR_FAULT] || exec_set[BIT_ERASE_SKIP_FLAG]
                   |=> (flg.flags[BIT_PROTECTED_WR_FAULT] || !$past(exec_set[BIT_PROTECTED_WR_FAULT])) &&
                       (flg.flags[BIT_ERASE_SKIP_FLAG] || !$past(exec_set[BIT_ERASE_SKIP_FLAG])))
    else $error("protection flag not stored");

  a_lock_fault_set:
  assert property (exec_set[BIT_LOCK_CMD_FAULT] |=> flg.flags[BIT_LOCK_CMD_FAULT])
    else $error("lock fault not stored");

  a_internal_set:
  assert property (|exec_set[BIT_ECC_UNCORR_FAULT -: 3]
                   |=> (flg.flags[BIT_ECC_UNCORR_FAULT -: 3] & $past(exec_set[BIT_ECC_UNCORR_FAULT -: 3]))
                       == $past(exec_set[BIT_ECC_UNCORR_FAULT -: 3]))
    else $error("internal fault not stored");

  a_id_rewrite_set:
  assert property (exec_set[BIT_ID_REG_REWRITE_FAULT] |=> flg.flags[BIT_ID_REG_REWRITE_FAULT])
    else $error("identity rewrite fault not stored");

  a_crc_flag_set:
  assert property (cmd_crc_fail |=> flg.flags[BIT_CMD_CHECK_FAULT])
    else $error("check fault not stored");

endmodule

// ===== tb/ccsr_host_model.sv
// ccsr_host_model: host side that issues commands and collects the answers
`timescale 1ns/1ps
module ccsr_host_model (
  input  wire logic                        core_clk,
  input  wire logic                        resp_valid,
  input  wire logic [ccsr_pkg::STAT_W-1:0] resp_status,
  output      logic                        cmd_rx,
  output      logic                        cmd_crc_fail,
  output      logic                        cmd_illegal
);
  initial begin
    cmd_rx = 1'b0;
    cmd_crc_fail = 1'b0;
    cmd_illegal = 1'b0;
  end

  // ==========================================================================
  // command traffic
  // caller stands at a falling edge; the answer is read one cycle later
  task automatic command(output logic v, output logic [ccsr_pkg::STAT_W-1:0] st);
    cmd_rx = 1'b1;
    @(negedge core_clk);
    cmd_rx = 1'b0;
    v = resp_valid;
    st = resp_status;
    // one idle cycle, so a following call never lowers and raises in one step
    @(negedge core_clk);
  endtask

  // a command failing its check code or illegal in this state gets no answer
  task automatic reject(input logic crc, output logic v);
    cmd_crc_fail = crc;
    cmd_illegal = ~crc;
    @(negedge core_clk);
    cmd_crc_fail = 1'b0;
    cmd_illegal = 1'b0;
    v = resp_valid;
  endtask
endmodule

// ===== tb/ccsr_regs_tb.sv
// ccsr_regs_tb: self-checking bench for the configuration and status registers
`timescale 1ns/1ps
module ccsr_regs_tb;
  import ccsr_pkg::*;
  logic             core_clk;
  logic             resetn;
  logic             cmd_rx;
  logic             cmd_crc_fail;
  logic             cmd_illegal;
  logic             host_lock_flag;
  logic             ecc_off;
  logic             cfg_rd;
  logic             cfg_ack;
  logic             resp_valid;
  logic [31:0]      resp_set;
  logic [31:0]      exec_set;
  logic [31:0]      resp_status;
  logic [63:0]      cfg_data;
  ccsr_card_state_t card_state;
  int               fail_count;
  int               checked;

  // state code 4 at bits 12:9, nothing else set
  localparam logic [31:0] BASE = 32'h0000_0800;
  localparam logic [31:0] RSVD = 32'h0006_0000;
  localparam logic [63:0] EXP_CFG = {4'h0, 4'h0, 1'b0, 3'h2, 4'h5, 16'h0000, 32'h0000_0000};

  ccsr_regs DUT (.core_clk(core_clk), .resetn(resetn), .cmd_rx(cmd_rx),
    .cmd_crc_fail(cmd_crc_fail), .cmd_illegal(cmd_illegal), .resp_set(resp_set),
    .exec_set(exec_set), .host_lock_flag(host_lock_flag), .ecc_off(ecc_off),
    .card_state(card_state), .cfg_rd(cfg_rd), .cfg_ack(cfg_ack), .cfg_data(cfg_data),
    .resp_valid(resp_valid), .resp_status(resp_status));

  ccsr_host_model host (.core_clk(core_clk), .resp_valid(resp_valid),
    .resp_status(resp_status), .cmd_rx(cmd_rx), .cmd_crc_fail(cmd_crc_fail),
    .cmd_illegal(cmd_illegal));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // compare and closing
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic cmd_expect(input logic [31:0] exp, input string what);
    logic        v;
    logic [31:0] st;
    host.command(v, st);
    chk_bit(v, 1'b1, "answer missing");
    chk({32'h0, st}, {32'h0, exp}, what);
  endtask

  task automatic conclude();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // a pending flag must not survive a reset in mid-run
  task automatic t_reset();
    exec_set = 32'h8000_0000;
    @(negedge core_clk);
    exec_set = '0;
    resetn = 1'b0;
    @(negedge core_clk);
    chk_bit(resp_valid | cfg_ack, 1'b0, "pulse in reset");
    chk({resp_status, 32'h0}, 64'h0, "status in reset");
    chk(cfg_data, 64'h0, "config in reset");
    resetn = 1'b1;
    @(negedge core_clk);
    cmd_expect(BASE, "flag kept over reset");
    $display("test reset done");
  endtask

  // two reads back to back, then the ack drops and bits 47:0 still read zero
  task automatic t_cfg();
    cfg_rd = 1'b1;
    @(negedge core_clk);
    chk_bit(cfg_ack, 1'b1, "first ack");
    chk(cfg_data, EXP_CFG, "config word");
    @(negedge core_clk);
    cfg_rd = 1'b0;
    chk_bit(cfg_ack, 1'b1, "second ack");
    chk(cfg_data[63:48], 16'h0025, "feature fields");
    chk_bit(cfg_data[54:52] != 3'h0, 1'b1, "security code zero");
    @(negedge core_clk);
    chk_bit(cfg_ack, 1'b0, "ack stays");
    chk(cfg_data[47:0], 48'h0, "reserved part");
    $display("test config done");
  endtask

  task automatic t_resp();
    int bits[4] = '{30, 29, 28, 13};
    resp_set = 32'h4000_0000;
    @(negedge core_clk);
    resp_set = '0;
    cmd_expect(BASE, "response flag without command");
    foreach (bits[i]) begin
      resp_set = (32'h1 << bits[i]) | RSVD;
      cmd_expect(BASE | (32'h1 << bits[i]), "response flag");
      resp_set = '0;
      cmd_expect(BASE, "response flag not cleared");
    end
    $display("test response flags done");
  endtask

  task automatic t_exec();
    int bits[9] = '{31, 27, 26, 24, 21, 20, 19, 16, 15};
    foreach (bits[i]) begin
      exec_set = (32'h1 << bits[i]) | RSVD;
      @(negedge core_clk);
      exec_set = '0;
      repeat (i % 2) @(negedge core_clk);
      cmd_expect(BASE | (32'h1 << bits[i]), "execution flag");
      cmd_expect(BASE, "execution flag not cleared");
    end
    $display("test execution flags done");
  endtask

  // an event in the capture cycle is reported twice, then gone
  task automatic t_capture();
    exec_set = 32'h0020_0000;
    fork
      cmd_expect(BASE | 32'h0020_0000, "event at capture");
      begin
        @(negedge core_clk);
        exec_set = '0;
      end
    join
    cmd_expect(BASE | 32'h0020_0000, "set lost to clear");
    cmd_expect(BASE, "event kept too long");
    $display("test capture done");
  endtask

  task automatic t_prev();
    logic v;
    for (int k = 0; k < 2; k++) begin
      host.reject(k == 0, v);
      chk_bit(v, 1'b0, "rejected command answered");
      cmd_expect(BASE | ((k == 0) ? 32'h0080_0000 : 32'h0040_0000), "previous fault");
      cmd_expect(BASE, "previous fault kept");
    end
    $display("test previous command done");
  endtask

  task automatic t_levels();
    logic [31:0] exp;
    for (int s = 0; s < 9; s++) begin
      card_state = ccsr_card_state_t'(s);
      host_lock_flag = s[0];
      ecc_off = s[1];
      exp = 32'h0;
      exp[12:9] = 4'(s);
      exp[25] = s[0];
      exp[14] = s[1];
      cmd_expect(exp, "state and levels");
    end
    card_state = CS_TRANSFER;
    host_lock_flag = 1'b0;
    ecc_off = 1'b0;
    $display("test levels done");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    fail_count = 0;
    checked = 0;
    resetn = 1'b0;
    cfg_rd = 1'b0;
    resp_set = '0;
    exec_set = '0;
    host_lock_flag = 1'b0;
    ecc_off = 1'b0;
    card_state = CS_TRANSFER;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    t_cfg();
    t_resp();
    t_exec();
    t_capture();
    t_prev();
    t_levels();
    t_reset();
    conclude();
  end

  // whole run is about 120 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule
